// [design/port_mux_pkg.sv]
// Purpose: Constants for the extended port pin data, direction and function select block
// Assumes: Byte-wide registers on the memory-mapped register port
// Notes: Functional notes follow
// Functional notes
// - Output pin drives high for stored 1, low for stored 0.
// - Data register writes are stored in input mode; pin unaffected.
// - Data register read returns sampled pin level in either direction.
// - Cold reset clears data bits; hot reset keeps them.
// - Direction bit per pin: 1 output, 0 input.
// - Cold reset clears direction bits; hot reset keeps them.
// - Direction read returns effective drive control, peripheral's when selected.
// - Function registers are eight bits holding two-bit fields per pin.
// - Cold reset clears function fields to 00; hot reset keeps them.
// - Three-pin port pin 0: 00 lower strobe, 01 I/O, 10 SDRAM column.
// - Three-pin port pin 1: 00 upper strobe, 01 I/O, 10 SDRAM row.
// - Three-pin port pin 2: 00 shared bus control, 01 plain I/O.
// - LCD data port: 00 plain I/O, 01 LCD data bit n.
// - LCD timing port: 01 routes frame, line, shift, bias to pins 0-3.
// - ROM strobe port pins 0-2: 01 routes read, low latch, high latch.
// - Input pin has its output driver disabled.
package port_mux_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_WIDTH = 24;
  localparam logic [23:0] ADDR_PA_DATA = 24'h30_0F40;
  localparam logic [23:0] ADDR_PA_DIR = 24'h30_0F41;
  localparam logic [23:0] ADDR_PB_DATA = 24'h30_0F42;
  localparam logic [23:0] ADDR_PB_DIR = 24'h30_0F43;
  localparam logic [23:0] ADDR_PC_DATA = 24'h30_0F44;
  localparam logic [23:0] ADDR_PC_DIR = 24'h30_0F45;
  localparam logic [23:0] ADDR_PD_DATA = 24'h30_0F46;
  localparam logic [23:0] ADDR_PD_DIR = 24'h30_0F47;
  localparam logic [23:0] ADDR_PA_FN = 24'h30_0F60;
  localparam logic [23:0] ADDR_PB_LO_FN = 24'h30_0F62;
  localparam logic [23:0] ADDR_PB_HI_FN = 24'h30_0F63;
  localparam logic [23:0] ADDR_PC_FN = 24'h30_0F64;
  localparam logic [23:0] ADDR_PD_FN = 24'h30_0F66;

  // ****************************************
  // Widths, masks and reset values
  // ****************************************
  localparam int PA_WIDTH = 3;
  localparam int PB_WIDTH = 8;
  localparam int PC_WIDTH = 4;
  localparam int PD_WIDTH = 8;
  localparam int PD_FN_PINS = 3;
  localparam int PA_BASE = 0;
  localparam int PB_BASE = PA_BASE + PA_WIDTH;
  localparam int PC_BASE = PB_BASE + PB_WIDTH;
  localparam int PD_BASE = PC_BASE + PC_WIDTH;
  localparam int PIN_COUNT = PD_BASE + PD_WIDTH;
  localparam logic [7:0] MASK_PA = 8'h07;
  localparam logic [7:0] MASK_PB = 8'hFF;
  localparam logic [7:0] MASK_PC = 8'h0F;
  localparam logic [7:0] MASK_PD = 8'hFF;
  localparam logic [7:0] MASK_FN_SIX = 8'h3F;
  localparam logic [7:0] MASK_FN_FULL = 8'hFF;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ****************************************
  // Pin function codes
  // ****************************************
  localparam logic [1:0] FN_CODE_00 = 2'h0;
  localparam logic [1:0] FN_CODE_01 = 2'h1;
  localparam logic [1:0] FN_CODE_10 = 2'h2;

endpackage

// [design/extended_port_pin_mux.sv]
// Purpose: Four extended I/O ports with per-pin peripheral function multiplexing
// Assumes: rst is the cold reset; a hot reset never reaches this block so state is kept
// Notes: Pin value and drive are registered; reserved function codes act as plain I/O
`timescale 1ns/100ps
module extended_port_pin_mux
  import port_mux_pkg::*;
(
  input logic clock,
  input logic rst,
  input logic clock_enable,
  input logic [ADDR_WIDTH-1:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input logic [PA_WIDTH-1:0] pa_pin_in,
  output logic [PA_WIDTH-1:0] pa_pin_out,
  output logic [PA_WIDTH-1:0] pa_pin_oe,
  input logic [PB_WIDTH-1:0] pb_pin_in,
  output logic [PB_WIDTH-1:0] pb_pin_out,
  output logic [PB_WIDTH-1:0] pb_pin_oe,
  input logic [PC_WIDTH-1:0] pc_pin_in,
  output logic [PC_WIDTH-1:0] pc_pin_out,
  output logic [PC_WIDTH-1:0] pc_pin_oe,
  input logic [PD_WIDTH-1:0] pd_pin_in,
  output logic [PD_WIDTH-1:0] pd_pin_out,
  output logic [PD_WIDTH-1:0] pd_pin_oe,
  input logic lower_column_strobe,
  input logic upper_column_strobe,
  input logic sdram_column_strobe,
  input logic sdram_row_strobe,
  input logic bus_control_out,
  input logic bus_control_oe,
  input logic [PB_WIDTH-1:0] lcd_pixel_data_out,
  input logic lcd_frame_start,
  input logic lcd_line_latch_clock,
  input logic lcd_shift_clock,
  input logic lcd_backplane_bias,
  input logic seq_rom_read_strobe,
  input logic seq_rom_low_addr_latch,
  input logic seq_rom_high_addr_latch
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Two-bit pin function field of a pin within a 16-bit field vector
  function automatic logic [1:0] field_of(input logic [15:0] fields, input int idx);
    field_of = fields[2*idx +: 2];
  endfunction

  // Address match qualified by an access strobe
  function automatic logic hit(input logic [23:0] addr, input logic [23:0] target, input logic strobe);
    hit = strobe && (addr == target);
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  // Only rst clears these, so a hot reset keeps every setting
  logic [7:0] pa_data_q, pb_data_q, pc_data_q, pd_data_q;
  logic [7:0] pa_dir_q, pb_dir_q, pc_dir_q, pd_dir_q;
  logic [7:0] pa_fn_q, pb_lo_fn_q, pb_hi_fn_q, pc_fn_q, pd_fn_q;
  logic [7:0] rdata_q;
  logic [PIN_COUNT-1:0] out_q, oe_q;

  // Write strobes per register
  // Exact address match, so the gaps between registers never alias
  wire wr_pa_data = hit(reg_addr, ADDR_PA_DATA, reg_wr);
  wire wr_pb_data = hit(reg_addr, ADDR_PB_DATA, reg_wr);
  wire wr_pc_data = hit(reg_addr, ADDR_PC_DATA, reg_wr);
  wire wr_pd_data = hit(reg_addr, ADDR_PD_DATA, reg_wr);
  wire wr_pa_dir = hit(reg_addr, ADDR_PA_DIR, reg_wr);
  wire wr_pb_dir = hit(reg_addr, ADDR_PB_DIR, reg_wr);
  wire wr_pc_dir = hit(reg_addr, ADDR_PC_DIR, reg_wr);
  wire wr_pd_dir = hit(reg_addr, ADDR_PD_DIR, reg_wr);
  wire wr_pa_fn = hit(reg_addr, ADDR_PA_FN, reg_wr);
  wire wr_pb_lo_fn = hit(reg_addr, ADDR_PB_LO_FN, reg_wr);
  wire wr_pb_hi_fn = hit(reg_addr, ADDR_PB_HI_FN, reg_wr);
  wire wr_pc_fn = hit(reg_addr, ADDR_PC_FN, reg_wr);
  wire wr_pd_fn = hit(reg_addr, ADDR_PD_FN, reg_wr);

  // Masked write values; unimplemented bits stay zero
  // Full-width registers pass the byte through unchanged
  wire [7:0] pa_wval = reg_wdata & MASK_PA;
  wire [7:0] pb_wval = reg_wdata & MASK_PB;
  wire [7:0] pc_wval = reg_wdata & MASK_PC;
  wire [7:0] pd_wval = reg_wdata & MASK_PD;
  wire [7:0] fn_six_wval = reg_wdata & MASK_FN_SIX;
  wire [7:0] fn_full_wval = reg_wdata & MASK_FN_FULL;

  // ****************************************
  // Data, direction and function registers
  // ****************************************

  // Data registers; stored regardless of direction
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pa_data_q <= REG_RESET;
      pb_data_q <= REG_RESET;
      pc_data_q <= REG_RESET;
      pd_data_q <= REG_RESET;
    end
    else if (clock_enable)
    begin
      if (wr_pa_data) pa_data_q <= pa_wval;
      if (wr_pb_data) pb_data_q <= pb_wval;
      if (wr_pc_data) pc_data_q <= pc_wval;
      if (wr_pd_data) pd_data_q <= pd_wval;
    end
  end

  // Direction registers; 1 output, 0 input
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pa_dir_q <= REG_RESET;
      pb_dir_q <= REG_RESET;
      pc_dir_q <= REG_RESET;
      pd_dir_q <= REG_RESET;
    end
    else if (clock_enable)
    begin
      if (wr_pa_dir) pa_dir_q <= pa_wval;
      if (wr_pb_dir) pb_dir_q <= pb_wval;
      if (wr_pc_dir) pc_dir_q <= pc_wval;
      if (wr_pd_dir) pd_dir_q <= pd_wval;
    end
  end

  // Function select registers
  // Port A and D fields stop at bit 5; bits 7:6 always hold zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pa_fn_q <= REG_RESET;
      pb_lo_fn_q <= REG_RESET;
      pb_hi_fn_q <= REG_RESET;
      pc_fn_q <= REG_RESET;
      pd_fn_q <= REG_RESET;
    end
    else if (clock_enable)
    begin
      if (wr_pa_fn) pa_fn_q <= fn_six_wval;
      if (wr_pb_lo_fn) pb_lo_fn_q <= fn_full_wval;
      if (wr_pb_hi_fn) pb_hi_fn_q <= fn_full_wval;
      if (wr_pc_fn) pc_fn_q <= fn_full_wval;
      if (wr_pd_fn) pd_fn_q <= fn_six_wval;
    end
  end

  // ****************************************
  // Peripheral routing
  // ****************************************
  // Flat per-pin peripheral select, value and drive across all ports
  logic [PIN_COUNT-1:0] periph_sel, periph_val, periph_oe;

  // Three-pin port codes
  // Reserved codes leave the select low, so the pin stays plain I/O
  wire [1:0] pa_code0 = field_of({8'h00, pa_fn_q}, 0);
  wire [1:0] pa_code1 = field_of({8'h00, pa_fn_q}, 1);
  wire [1:0] pa_code2 = field_of({8'h00, pa_fn_q}, 2);

  // Pin 0: lower column strobe or SDRAM column strobe
  // Memory strobes always drive while routed
  assign periph_sel[PA_BASE] = (pa_code0 == FN_CODE_00) || (pa_code0 == FN_CODE_10);
  assign periph_val[PA_BASE] = (pa_code0 == FN_CODE_00) ? lower_column_strobe : sdram_column_strobe;
  assign periph_oe[PA_BASE] = 1'b1;

  // Pin 1: upper column strobe or SDRAM row strobe
  assign periph_sel[PA_BASE+1] = (pa_code1 == FN_CODE_00) || (pa_code1 == FN_CODE_10);
  assign periph_val[PA_BASE+1] = (pa_code1 == FN_CODE_00) ? upper_column_strobe : sdram_row_strobe;
  assign periph_oe[PA_BASE+1] = 1'b1;

  // Pin 2: shared bus control owns value and drive
  // Bus control may release the pin, as when it serves as a wait input
  assign periph_sel[PA_BASE+2] = (pa_code2 == FN_CODE_00);
  assign periph_val[PA_BASE+2] = bus_control_out;
  assign periph_oe[PA_BASE+2] = bus_control_oe;

  // LCD data and timing, ROM strobe ports
  // Timing and strobe signals gathered so a loop can index them
  wire [15:0] pb_fields = {pb_hi_fn_q, pb_lo_fn_q};
  wire [PC_WIDTH-1:0] lcd_timing = {lcd_backplane_bias, lcd_shift_clock, lcd_line_latch_clock, lcd_frame_start};
  wire [PD_FN_PINS-1:0] rom_strobes = {seq_rom_high_addr_latch, seq_rom_low_addr_latch, seq_rom_read_strobe};

  genvar gi;
  generate
    // LCD data pin n takes controller data bit n
    for (gi = 0; gi < PB_WIDTH; gi++)
    begin : g_lcd_data
      assign periph_sel[PB_BASE+gi] = (field_of(pb_fields, gi) == FN_CODE_01);
      assign periph_val[PB_BASE+gi] = lcd_pixel_data_out[gi];
      assign periph_oe[PB_BASE+gi] = 1'b1;
    end
    // LCD timing pins: frame, line, shift, bias
    for (gi = 0; gi < PC_WIDTH; gi++)
    begin : g_lcd_timing
      assign periph_sel[PC_BASE+gi] = (field_of({8'h00, pc_fn_q}, gi) == FN_CODE_01);
      assign periph_val[PC_BASE+gi] = lcd_timing[gi];
      assign periph_oe[PC_BASE+gi] = 1'b1;
    end
    // ROM strobes on pins 0-2; upper pins are plain I/O only
    for (gi = 0; gi < PD_WIDTH; gi++)
    begin : g_rom_strobe
      if (gi < PD_FN_PINS)
      begin : g_muxed
        assign periph_sel[PD_BASE+gi] = (field_of({8'h00, pd_fn_q}, gi) == FN_CODE_01);
        assign periph_val[PD_BASE+gi] = rom_strobes[gi];
        assign periph_oe[PD_BASE+gi] = 1'b1;
      end
      else
      begin : g_plain
        assign periph_sel[PD_BASE+gi] = 1'b0;
        assign periph_val[PD_BASE+gi] = 1'b0;
        assign periph_oe[PD_BASE+gi] = 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Pin drive
  // ****************************************
  // Flat data and direction vectors, port A in the low bits
  wire [PIN_COUNT-1:0] reg_data = {pd_data_q[PD_WIDTH-1:0], pc_data_q[PC_WIDTH-1:0],
                                   pb_data_q[PB_WIDTH-1:0], pa_data_q[PA_WIDTH-1:0]};
  wire [PIN_COUNT-1:0] reg_dir = {pd_dir_q[PD_WIDTH-1:0], pc_dir_q[PC_WIDTH-1:0],
                                  pb_dir_q[PB_WIDTH-1:0], pa_dir_q[PA_WIDTH-1:0]};

  // Peripheral overrides registers when its function is chosen
  // Drive enable picks the peripheral's or the direction bit, per pin
  wire [PIN_COUNT-1:0] out_d = (periph_sel & periph_val) | (~periph_sel & reg_data);
  wire [PIN_COUNT-1:0] oe_d = (periph_sel & periph_oe) | (~periph_sel & reg_dir);

  // Registered pin value and enable
  // Pins change one cycle after their cause; no glitches reach the pads
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      out_q <= '0;
      oe_q <= '0;
    end
    else if (clock_enable)
    begin
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // Split the flat vectors back into ports
  assign pa_pin_out = out_q[PA_BASE +: PA_WIDTH];
  assign pa_pin_oe = oe_q[PA_BASE +: PA_WIDTH];
  assign pb_pin_out = out_q[PB_BASE +: PB_WIDTH];
  assign pb_pin_oe = oe_q[PB_BASE +: PB_WIDTH];
  assign pc_pin_out = out_q[PC_BASE +: PC_WIDTH];
  assign pc_pin_oe = oe_q[PC_BASE +: PC_WIDTH];
  assign pd_pin_out = out_q[PD_BASE +: PD_WIDTH];
  assign pd_pin_oe = oe_q[PD_BASE +: PD_WIDTH];

  // ****************************************
  // Register read
  // ****************************************

  // Pin levels and effective drive control, zero-extended
  wire [7:0] pa_pin_rd = {{(8-PA_WIDTH){1'b0}}, pa_pin_in};
  wire [7:0] pc_pin_rd = {{(8-PC_WIDTH){1'b0}}, pc_pin_in};
  wire [7:0] pa_oe_rd = {{(8-PA_WIDTH){1'b0}}, pa_pin_oe};
  wire [7:0] pc_oe_rd = {{(8-PC_WIDTH){1'b0}}, pc_pin_oe};

  // Read selection; unmapped addresses answer zero
  // Data reads show the pin, which lags a data write by one cycle
  wire [7:0] read_mux =
    (reg_addr == ADDR_PA_DATA) ? pa_pin_rd :
    (reg_addr == ADDR_PB_DATA) ? pb_pin_in :
    (reg_addr == ADDR_PC_DATA) ? pc_pin_rd :
    (reg_addr == ADDR_PD_DATA) ? pd_pin_in :
    (reg_addr == ADDR_PA_DIR) ? pa_oe_rd :
    (reg_addr == ADDR_PB_DIR) ? pb_pin_oe :
    (reg_addr == ADDR_PC_DIR) ? pc_oe_rd :
    (reg_addr == ADDR_PD_DIR) ? pd_pin_oe :
    (reg_addr == ADDR_PA_FN) ? pa_fn_q :
    (reg_addr == ADDR_PB_LO_FN) ? pb_lo_fn_q :
    (reg_addr == ADDR_PB_HI_FN) ? pb_hi_fn_q :
    (reg_addr == ADDR_PC_FN) ? pc_fn_q :
    (reg_addr == ADDR_PD_FN) ? pd_fn_q :
    READ_IDLE;

  // Read data captured on the read strobe
  // Holds between reads so software sees a stable byte
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_q <= READ_IDLE;
    else if (clock_enable && reg_rd)
      rdata_q <= read_mux;
  end

  assign reg_rdata = rdata_q;

endmodule

// [test/pin_partner.sv]
// Purpose: Outside world at one port's pins
// Assumes: Outside source drives only while the block does not
// Notes: Resolved level fed back to the pin inputs
`timescale 1ns/100ps
module pin_partner #(parameter int W = 8)
(
  input logic [W-1:0] pin_out,
  input logic [W-1:0] pin_oe,
  input logic [W-1:0] ext_level,
  output logic [W-1:0] pin_in
);
  // Block's driver wins, else outside level shows
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule

// [test/port_mux_checker.sv]
// Purpose: Port-level checks of the extended port block
// Assumes: clock_enable stays high for two cycles after a port C direction write
// Notes: Shadows port A and C registers from the write strobe
`timescale 1ns/100ps
module port_mux_checker
  import port_mux_pkg::*;
(
  input logic clock,
  input logic rst,
  input logic clock_enable,
  input logic [ADDR_WIDTH-1:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic [PA_WIDTH-1:0] pa_pin_in,
  input logic [PA_WIDTH-1:0] pa_pin_out,
  input logic [PA_WIDTH-1:0] pa_pin_oe,
  input logic [PC_WIDTH-1:0] pc_pin_out,
  input logic [PC_WIDTH-1:0] pc_pin_oe,
  input logic lower_column_strobe,
  input logic sdram_column_strobe,
  input logic bus_control_out,
  input logic bus_control_oe,
  input logic lcd_frame_start,
  input logic lcd_line_latch_clock,
  input logic lcd_shift_clock,
  input logic lcd_backplane_bias
);
  // ****************************************
  // Shadow registers and expected pins
  // ****************************************
  logic [7:0] a_dat_q, a_dir_q, a_fn_q, c_dat_q, c_dir_q, c_fn_q;
  wire wr_take = reg_wr && clock_enable;
  wire rd_take = reg_rd && clock_enable;
  wire mapped = reg_addr inside {ADDR_PA_DATA, ADDR_PA_DIR, ADDR_PB_DATA, ADDR_PB_DIR, ADDR_PC_DATA,
    ADDR_PC_DIR, ADDR_PD_DATA, ADDR_PD_DIR, ADDR_PA_FN, ADDR_PB_LO_FN, ADDR_PB_HI_FN, ADDR_PC_FN, ADDR_PD_FN};
  wire [3:0] c_wdir = reg_wdata[3:0];
  // Shadow copies follow taken writes
  always_ff @(posedge clock or posedge rst)
    if (rst)
      {a_dat_q, a_dir_q, a_fn_q, c_dat_q, c_dir_q, c_fn_q} <= '0;
    else if (wr_take)
      case (reg_addr)
        ADDR_PA_DATA: a_dat_q <= reg_wdata;
        ADDR_PA_DIR: a_dir_q <= reg_wdata;
        ADDR_PA_FN: a_fn_q <= reg_wdata;
        ADDR_PC_DATA: c_dat_q <= reg_wdata;
        ADDR_PC_DIR: c_dir_q <= reg_wdata;
        ADDR_PC_FN: c_fn_q <= reg_wdata;
        default: ;
      endcase
  // Expected pin values from shadows
  wire [1:0] a0_fn = a_fn_q[1:0];
  wire a0_per = (a0_fn == FN_CODE_00) || (a0_fn == FN_CODE_10);
  wire a0_out_exp = (a0_fn == FN_CODE_00) ? lower_column_strobe :
    (a0_fn == FN_CODE_10) ? sdram_column_strobe : a_dat_q[0];
  wire a0_oe_exp = a0_per || a_dir_q[0];
  wire a2_bus = a_fn_q[5:4] == FN_CODE_00;
  wire a2_out_exp = a2_bus ? bus_control_out : a_dat_q[2];
  wire a2_oe_exp = a2_bus ? bus_control_oe : a_dir_q[2];
  wire [3:0] c_sel = {c_fn_q[7:6] == FN_CODE_01, c_fn_q[5:4] == FN_CODE_01, c_fn_q[3:2] == FN_CODE_01,
    c_fn_q[1:0] == FN_CODE_01};
  wire [3:0] c_per = {lcd_backplane_bias, lcd_shift_clock, lcd_line_latch_clock, lcd_frame_start};
  wire [3:0] c_out_exp = (c_sel & c_per) | (~c_sel & c_dat_q[3:0]);
  wire [3:0] c_oe_exp = c_sel | c_dir_q[3:0];
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ****************************************
  // Assertions
  // ****************************************
  property p_unmapped; rd_take && !mapped |=> reg_rdata == READ_IDLE; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_pa_data; rd_take && reg_addr == ADDR_PA_DATA |=> reg_rdata == {5'h00, $past(pa_pin_in)}; endproperty
  a_rd_pa_data: assert property (p_rd_pa_data) else $error("port A data read wrong");
  property p_rd_pa_dir; rd_take && reg_addr == ADDR_PA_DIR |=> reg_rdata == {5'h00, $past(pa_pin_oe)}; endproperty
  a_rd_pa_dir: assert property (p_rd_pa_dir) else $error("port A direction read wrong");
  property p_rd_pc_fn; rd_take && reg_addr == ADDR_PC_FN |=> reg_rdata == $past(c_fn_q); endproperty
  a_rd_pc_fn: assert property (p_rd_pc_fn) else $error("port C function read wrong");
  property p_pc_out; clock_enable |=> pc_pin_out == $past(c_out_exp); endproperty
  a_pc_out: assert property (p_pc_out) else $error("port C pin value wrong");
  property p_pc_oe; clock_enable |=> pc_pin_oe == $past(c_oe_exp); endproperty
  a_pc_oe: assert property (p_pc_oe) else $error("port C drive wrong");
  property p_pa0; clock_enable |=> pa_pin_out[0] == $past(a0_out_exp) && pa_pin_oe[0] == $past(a0_oe_exp); endproperty
  a_pa0: assert property (p_pa0) else $error("port A pin 0 routing wrong");
  property p_pa2; clock_enable |=> pa_pin_out[2] == $past(a2_out_exp) && pa_pin_oe[2] == $past(a2_oe_exp); endproperty
  a_pa2: assert property (p_pa2) else $error("port A pin 2 routing wrong");
  property p_dir_write;
    (wr_take && reg_addr == ADDR_PC_DIR && c_fn_q == REG_RESET) ##1 !reg_wr |=> pc_pin_oe == $past(c_wdir, 2);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not on pins");
  c_unmapped: cover property (rd_take && !mapped);
  c_pa_dir: cover property (rd_take && reg_addr == ADDR_PA_DIR);
  c_lcd_timing: cover property (c_sel == 4'hF);
  c_frozen_write: cover property (reg_wr && !clock_enable);
endmodule
bind extended_port_pin_mux port_mux_checker port_mux_checker_inst (.clock, .rst, .clock_enable, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .pa_pin_in, .pa_pin_out, .pa_pin_oe, .pc_pin_out, .pc_pin_oe,
  .lower_column_strobe, .sdram_column_strobe, .bus_control_out, .bus_control_oe, .lcd_frame_start,
  .lcd_line_latch_clock, .lcd_shift_clock, .lcd_backplane_bias);

// [test/tb.sv]
// Purpose: Register and pin tests of the extended port block
// Assumes: Outside levels come from pin_partner
// Notes: Expected values worked out by hand per scenario
`timescale 1ns/100ps
module tb
  import port_mux_pkg::*;
;
  logic clock = 0, rst = 1, clock_enable = 1, reg_wr = 0, reg_rd = 0;
  logic [ADDR_WIDTH-1:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, pb_pin_in, pb_pin_out, pb_pin_oe, pd_pin_in, pd_pin_out, pd_pin_oe;
  logic [2:0] pa_pin_in, pa_pin_out, pa_pin_oe, ao, ae, ext_a = '0;
  logic [3:0] pc_pin_in, pc_pin_out, pc_pin_oe, ext_c = '0;
  logic [7:0] ext_b = '0, ext_d = '0, lcd_pixel_data_out = '0;
  logic lower_column_strobe = 0, upper_column_strobe = 0, sdram_column_strobe = 0, sdram_row_strobe = 0;
  logic bus_control_out = 0, bus_control_oe = 0, seq_rom_read_strobe = 0, seq_rom_low_addr_latch = 0;
  logic lcd_frame_start = 0, lcd_line_latch_clock = 0, lcd_shift_clock = 0, lcd_backplane_bias = 0;
  logic seq_rom_high_addr_latch = 0;
  int fail_count = 0, num_checks = 0, cycles = 0;
  logic [23:0] map_addr [13] = '{ADDR_PA_DATA, ADDR_PA_DIR, ADDR_PB_DATA, ADDR_PB_DIR, ADDR_PC_DATA, ADDR_PC_DIR,
    ADDR_PD_DATA, ADDR_PD_DIR, ADDR_PA_FN, ADDR_PB_LO_FN, ADDR_PB_HI_FN, ADDR_PC_FN, ADDR_PD_FN};
  logic [23:0] bad_addr [3] = '{24'h30_0F48, 24'h30_0F61, 24'h30_0F65};
  always #20 clock = ~clock;
  extended_port_pin_mux extended_port_pin_mux_inst (.clock, .rst, .clock_enable, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .pa_pin_in, .pa_pin_out, .pa_pin_oe, .pb_pin_in, .pb_pin_out, .pb_pin_oe,
    .pc_pin_in, .pc_pin_out, .pc_pin_oe, .pd_pin_in, .pd_pin_out, .pd_pin_oe, .lower_column_strobe,
    .upper_column_strobe, .sdram_column_strobe, .sdram_row_strobe, .bus_control_out, .bus_control_oe,
    .lcd_pixel_data_out, .lcd_frame_start, .lcd_line_latch_clock, .lcd_shift_clock, .lcd_backplane_bias,
    .seq_rom_read_strobe, .seq_rom_low_addr_latch, .seq_rom_high_addr_latch);
  pin_partner #(.W(3)) pin_partner_a_inst (.pin_out(pa_pin_out), .pin_oe(pa_pin_oe), .ext_level(ext_a),
    .pin_in(pa_pin_in));
  pin_partner #(.W(8)) pin_partner_b_inst (.pin_out(pb_pin_out), .pin_oe(pb_pin_oe), .ext_level(ext_b),
    .pin_in(pb_pin_in));
  pin_partner #(.W(4)) pin_partner_c_inst (.pin_out(pc_pin_out), .pin_oe(pc_pin_oe), .ext_level(ext_c),
    .pin_in(pc_pin_in));
  pin_partner #(.W(8)) pin_partner_d_inst (.pin_out(pd_pin_out), .pin_oe(pd_pin_oe), .ext_level(ext_d),
    .pin_in(pd_pin_in));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    settle;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    settle;
    reg_wr = 0;
  endtask
  task automatic rd_check(input logic [23:0] a, input logic [7:0] exp);
    settle;
    reg_addr = a;
    reg_rd = 1;
    settle;
    reg_rd = 0;
    check(reg_rdata, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clock);
    #1;
    rst = 0;
    // Reset contents; port A pins 0-1 drive from the strobes, pin 2 released by bus control
    for (int i = 0; i < 13; i++)
      rd_check(map_addr[i], (i == 1) ? 8'h03 : 8'h00);
    // Unmapped places
    for (int i = 0; i < 3; i++)
    begin
      wr(bad_addr[i], 8'hFF);
      rd_check(bad_addr[i], 8'h00);
    end
    rd_check(ADDR_PB_LO_FN, 8'h00);
    // Unimplemented upper bits
    wr(ADDR_PC_DIR, 8'hFF);
    rd_check(ADDR_PC_DIR, 8'h0F);
    wr(ADDR_PC_DATA, 8'hFF);
    rd_check(ADDR_PC_DATA, 8'h0F);
    wr(ADDR_PC_FN, 8'hFF);
    rd_check(ADDR_PC_FN, 8'hFF);
    wr(ADDR_PA_FN, 8'hFF);
    rd_check(ADDR_PA_FN, 8'h3F);
    wr(ADDR_PD_FN, 8'hFF);
    rd_check(ADDR_PD_FN, 8'h3F);
    wr(ADDR_PA_DIR, 8'hFF);
    rd_check(ADDR_PA_DIR, 8'h07);
    // Port B data stored while input, then driven
    ext_b = 8'h3C;
    wr(ADDR_PB_DATA, 8'hA5);
    settle;
    check(pb_pin_oe, 8'h00);
    rd_check(ADDR_PB_DATA, 8'h3C);
    wr(ADDR_PB_DIR, 8'hFF);
    settle;
    check(pb_pin_out, 8'hA5);
    check(pb_pin_oe, 8'hFF);
    rd_check(ADDR_PB_DATA, 8'hA5);
    // LCD data on low nibble, reserved codes on high nibble
    lcd_pixel_data_out = 8'h96;
    wr(ADDR_PB_LO_FN, 8'h55);
    wr(ADDR_PB_HI_FN, 8'hAA);
    wr(ADDR_PB_DIR, 8'h00);
    settle;
    check(pb_pin_out, 8'hA6);
    check(pb_pin_oe, 8'h0F);
    rd_check(ADDR_PB_DIR, 8'h0F);
    rd_check(ADDR_PB_DATA, 8'h36);
    // LCD timing and ROM strobes
    {lcd_backplane_bias, lcd_shift_clock, lcd_line_latch_clock, lcd_frame_start} = 4'hA;
    {seq_rom_high_addr_latch, seq_rom_low_addr_latch, seq_rom_read_strobe} = 3'h5;
    wr(ADDR_PC_FN, 8'h55);
    wr(ADDR_PC_DIR, 8'h00);
    wr(ADDR_PD_FN, 8'h15);
    wr(ADDR_PD_DIR, 8'hF8);
    wr(ADDR_PD_DATA, 8'h88);
    settle;
    check({4'h0, pc_pin_out}, 8'h0A);
    check({4'h0, pc_pin_oe}, 8'h0F);
    check(pd_pin_out, 8'h8D);
    check(pd_pin_oe, 8'hFF);
    // Port A every function code
    {lower_column_strobe, upper_column_strobe, sdram_column_strobe, sdram_row_strobe} = 4'hD;
    {bus_control_out, bus_control_oe} = 2'h3;
    ext_a = 3'h4;
    wr(ADDR_PA_DATA, 8'h01);
    wr(ADDR_PA_DIR, 8'h03);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_PA_FN, {2'h0, c[1:0], c[1:0], c[1:0]});
      ao = (c == 0) ? 3'h7 : (c == 2) ? 3'h2 : 3'h1;
      ae = (c == 0) ? 3'h7 : 3'h3;
      settle;
      check({5'h00, pa_pin_out}, {5'h00, ao});
      check({5'h00, pa_pin_oe}, {5'h00, ae});
      rd_check(ADDR_PA_DIR, {5'h00, ae});
      rd_check(ADDR_PA_DATA, {5'h00, (ao & ae) | (ext_a & ~ae)});
    end
    // Clock enable low freezes registers, pins and read data
    ext_c = 4'h3;
    ext_d = 8'h5A;
    clock_enable = 0;
    wr(ADDR_PD_DATA, 8'h00);
    rd_check(ADDR_PD_DATA, 8'h05);
    check(pd_pin_out, 8'h8D);
    clock_enable = 1;
    settle;
    check(pd_pin_out, 8'h8D);
    // Plain input pins show the outside level
    wr(ADDR_PC_FN, 8'h00);
    wr(ADDR_PD_FN, 8'h00);
    wr(ADDR_PD_DIR, 8'h00);
    rd_check(ADDR_PC_DATA, 8'h03);
    rd_check(ADDR_PD_DATA, 8'h5A);
    report_and_stop;
  end
endmodule
